// ==== design/cabw_alu.sv ====
// Eight-bit complement, decrement and increment unit with zero detect
`timescale 1ns/1ps
module cabw_alu #(
  parameter int WIDTH = 8
) (
  // Operation
  input  wire cabw_pkg::cabw_kind_t kind,
  input  wire logic [WIDTH-1:0]     operand,
  // Result
  output logic      [WIDTH-1:0]     result,
  output logic                      zero
);
  import cabw_pkg::*;

  always_comb begin
    case (kind)
      K_COM:   result = ~operand;
      K_DEC:   result = operand - WIDTH'(1);
      K_INC:   result = operand + WIDTH'(1);
      default: result = operand;
    endcase
    zero = (result == '0);
  end
endmodule

// ==== design/cabw_decoder.sv ====
// Decode and execute unit for watchdog clear, complement, decrement, skip, jump, increment
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps
// How it works
// - The watchdog-clear opcode pulses the watchdog clear and turns the watchdog enable on.
// - Watchdog clear takes one cycle, leaves the count at zero and sets timeout and powerdown status.
// - Complement inverts the addressed file register in one cycle, to the accumulator or back.
// - A complement sent to the accumulator leaves the source register unwritten.
// - Decrement subtracts one in one cycle and writes the chosen destination.
// - Complement, decrement and increment update zero from the result, so 0x01 minus one sets it.
// - Decrement-and-skip writes its destination, changes no flag and skips nothing if nonzero.
// - A zero decrement-and-skip result discards the next opcode and runs a NOP in its place for one cycle.
// - The jump loads its twelve-bit target into the low program counter bits and nothing else.
// - Every jump takes two cycles, flushing the opcode fetched behind it.
// - Increment adds one in one cycle and writes the chosen destination.
// - Incrementing 0xff wraps to 0x00 and sets zero.
// - File operations take a seven-bit address from the low bits and the destination above it.
module cabw_decoder (
  // Clock and reset
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  // APB slave
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [cabw_pkg::PADDR_W-1:0]    paddr,
  input  wire logic [31:0]                     pwdata,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  // Opcode and operand from fetch and register file
  input  wire logic                            op_valid,
  input  wire logic [cabw_pkg::OP_W-1:0]       opcode,
  input  wire logic [cabw_pkg::DATA_W-1:0]     file_rdata,
  // Watchdog events
  input  wire logic                            wdt_timeout,
  input  wire logic                            sleep_entry,
  // File register write
  output logic      [cabw_pkg::FADDR_W-1:0]    file_addr,
  output logic                                 file_we,
  output logic      [cabw_pkg::DATA_W-1:0]     file_wdata,
  // Accumulator write
  output logic                                 acc_we,
  output logic      [cabw_pkg::DATA_W-1:0]     acc_wdata,
  // Zero flag update
  output logic                                 zero_we,
  output logic                                 zero_value,
  // Program counter and pipeline
  output logic                                 pc_load,
  output logic      [cabw_pkg::JUMP_W-1:0]     pc_target,
  output logic                                 flush_pulse,
  output cabw_pkg::cabw_state_t                state,
  // Watchdog control and status
  output logic                                 wdt_clear,
  output logic                                 watchdog_enable_ctl,
  output logic                                 timeout_status_bit,
  output logic                                 powerdown_status_bit
);
  import cabw_pkg::*;

  logic                decode_en;
  logic                op_take;
  logic                is_wdt_clear;
  logic                is_jump;
  logic                is_dec_skip;
  logic                dest_file;
  logic [5:0]          group;
  cabw_kind_t          kind;
  logic [DATA_W-1:0]   alu_result;
  logic                alu_zero;
  logic [DATA_W-1:0]   last_result;
  cabw_state_t         next_state;
  logic                apb_setup;
  logic                apb_wr;
  logic                apb_rd;
  logic                addr_hit;

  // Decode
  assign op_take = op_valid && decode_en && (state == ST_RUN);
  assign group = opcode[OP_W-1:GROUP_LSB];
  assign dest_file = opcode[DEST_BIT];
  assign is_wdt_clear = (opcode == WDT_CLEAR_CODE);
  assign is_jump = (opcode[OP_W-1:JUMP_LSB] == JUMP_CODE);
  assign is_dec_skip = (group == DEC_SKIP_CODE);

  always_comb begin
    case (group)
      COMPLEMENT_CODE: kind = K_COM;
      DECREMENT_CODE:  kind = K_DEC;
      DEC_SKIP_CODE:   kind = K_DEC;
      INCREMENT_CODE:  kind = K_INC;
      default:         kind = K_NONE;
    endcase
  end

  cabw_alu #(
    .WIDTH (DATA_W)
  ) u_alu (
    .kind    (kind),
    .operand (file_rdata),
    .result  (alu_result),
    .zero    (alu_zero)
  );

  // Sequencer: NOP slot after a taken skip or a jump
  always_comb begin
    case (state)
      ST_RUN: begin
        if (op_take && (is_jump || (is_dec_skip && alu_zero))) begin
          next_state = ST_NOP;
        end else begin
          next_state = ST_RUN;
        end
      end
      ST_NOP:  next_state = ST_RUN;
      default: next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flush_pulse <= 1'b0;
    end else begin
      flush_pulse <= (next_state == ST_NOP);
    end
  end

  // Destination writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      file_addr <= '0;
      file_we <= 1'b0;
      file_wdata <= '0;
      acc_we <= 1'b0;
      acc_wdata <= '0;
      last_result <= '0;
    end else begin
      file_we <= 1'b0;
      acc_we <= 1'b0;
      if (op_take && (kind != K_NONE)) begin
        file_addr <= opcode[FADDR_W-1:0];
        file_we <= dest_file;
        acc_we <= !dest_file;
        file_wdata <= alu_result;
        acc_wdata <= alu_result;
        last_result <= alu_result;
      end
    end
  end

  // Zero flag; the skip form leaves it alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_we <= 1'b0;
      zero_value <= 1'b0;
    end else begin
      zero_we <= 1'b0;
      if (op_take && (kind != K_NONE) && !is_dec_skip) begin
        zero_we <= 1'b1;
        zero_value <= alu_zero;
      end
    end
  end

  // Jump
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_load <= 1'b0;
      pc_target <= '0;
    end else begin
      pc_load <= op_take && is_jump;
      if (op_take && is_jump) begin
        pc_target <= opcode[JUMP_W-1:0];
      end
    end
  end

  // Watchdog clear and status; the clear opcode's set wins over a timeout or sleep-entry clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_clear <= 1'b0;
      watchdog_enable_ctl <= CTRL_WDT_EN_RST;
      timeout_status_bit <= TIMEOUT_RST;
      powerdown_status_bit <= POWERDOWN_RST;
    end else begin
      wdt_clear <= op_take && is_wdt_clear;
      if (op_take && is_wdt_clear) begin
        watchdog_enable_ctl <= 1'b1;
        timeout_status_bit <= 1'b1;
        powerdown_status_bit <= 1'b1;
      end else begin
        if (apb_wr && (paddr == CTRL_OFF)) begin
          watchdog_enable_ctl <= pwdata[CTRL_WDT_EN];
        end
        if (wdt_timeout) begin
          timeout_status_bit <= 1'b0;
        end
        if (sleep_entry) begin
          powerdown_status_bit <= 1'b0;
        end
      end
    end
  end

  // APB slave: one wait state, answer registered; writes land as pready is sampled
  assign apb_setup = psel && penable && !pready;
  assign apb_wr = psel && penable && pready && pwrite;
  assign apb_rd = apb_setup && !pwrite;
  assign addr_hit = (paddr == CTRL_OFF) || (paddr == STAT_OFF) || (paddr == RESULT_OFF);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      decode_en <= CTRL_DECODE_EN_RST;
    end else if (apb_wr && (paddr == CTRL_OFF)) begin
      decode_en <= pwdata[CTRL_DECODE_EN];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup && !addr_hit;
      prdata <= '0;
      if (apb_rd) begin
        case (paddr)
          CTRL_OFF:   prdata <= {30'h0, watchdog_enable_ctl, decode_en};
          STAT_OFF:   prdata <= {28'h0, state, watchdog_enable_ctl, powerdown_status_bit,
                                 timeout_status_bit};
          RESULT_OFF: prdata <= {24'h0, last_result};
          default:    prdata <= 32'h0;
        endcase
      end
    end
  end

  // Checks
  sequence s_take(logic [5:0] g);
    op_take && (group == g);
  endsequence

  sequence s_skip_slot;
    flush_pulse && (state == ST_NOP) ##1 (state == ST_RUN) && !file_we && !acc_we && !zero_we;
  endsequence

  property p_wdt_clear;
    @(posedge pclk) disable iff (!presetn)
    op_take && is_wdt_clear |=> wdt_clear && watchdog_enable_ctl ##1
      (!wdt_clear || $past(op_take && is_wdt_clear));
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog clear not pulsed");

  property p_wdt_status;
    @(posedge pclk) disable iff (!presetn)
    op_take && is_wdt_clear |=> timeout_status_bit && powerdown_status_bit && !pc_load;
  endproperty
  a_wdt_status: assert property (p_wdt_status) else $error("watchdog status not set");

  property p_com_acc;
    @(posedge pclk) disable iff (!presetn)
    s_take(COMPLEMENT_CODE) and !dest_file |=>
      acc_we && !file_we && (acc_wdata == ~$past(file_rdata)) && (state == ST_RUN);
  endproperty
  a_com_acc: assert property (p_com_acc) else $error("complement to accumulator wrong");

  property p_dec_file;
    @(posedge pclk) disable iff (!presetn)
    s_take(DECREMENT_CODE) and dest_file |=>
      file_we && (file_wdata == DATA_W'($past(file_rdata) - ONE8)) && !acc_we;
  endproperty
  a_dec_file: assert property (p_dec_file) else $error("decrement to file wrong");

  property p_dec_zero;
    @(posedge pclk) disable iff (!presetn)
    s_take(DECREMENT_CODE) and (file_rdata == ONE8) |=> zero_we && zero_value;
  endproperty
  a_dec_zero: assert property (p_dec_zero) else $error("zero not set by decrement");

  property p_skip_none;
    @(posedge pclk) disable iff (!presetn)
    s_take(DEC_SKIP_CODE) and (file_rdata != ONE8) |=> !zero_we && !flush_pulse &&
      (state == ST_RUN);
  endproperty
  a_skip_none: assert property (p_skip_none) else $error("nonzero skip misbehaved");

  property p_skip_taken;
    @(posedge pclk) disable iff (!presetn)
    s_take(DEC_SKIP_CODE) and (file_rdata == ONE8) |=> s_skip_slot;
  endproperty
  a_skip_taken: assert property (p_skip_taken) else $error("zero skip did not NOP");

  property p_jump;
    @(posedge pclk) disable iff (!presetn)
    op_take && is_jump |=> pc_load && (pc_target == $past(opcode[JUMP_W-1:0])) &&
      !zero_we && !acc_we ##1 !pc_load && (state == ST_RUN);
  endproperty
  a_jump: assert property (p_jump) else $error("jump target or length wrong");

  property p_inc_wrap;
    @(posedge pclk) disable iff (!presetn)
    s_take(INCREMENT_CODE) and (file_rdata == 8'hff) |=>
      zero_we && zero_value && ((file_we && file_wdata == ZERO8) || (acc_we && acc_wdata == ZERO8));
  endproperty
  a_inc_wrap: assert property (p_inc_wrap) else $error("increment wrap wrong");

  property p_faddr;
    @(posedge pclk) disable iff (!presetn)
    op_take && (kind != K_NONE) |=> (file_addr == $past(opcode[FADDR_W-1:0])) &&
      (file_we == $past(dest_file));
  endproperty
  a_faddr: assert property (p_faddr) else $error("file address or destination wrong");

  property p_zero_clear;
    @(posedge pclk) disable iff (!presetn)
    op_take && (kind != K_NONE) && !is_dec_skip && !alu_zero |=> zero_we && !zero_value;
  endproperty
  a_zero_clear: assert property (p_zero_clear) else $error("zero not cleared");

  property p_other;
    @(posedge pclk) disable iff (!presetn)
    op_take && (kind == K_NONE) && !is_jump && !is_wdt_clear |=>
      !file_we && !acc_we && !zero_we && !pc_load && (state == ST_RUN);
  endproperty
  a_other: assert property (p_other) else $error("foreign opcode caused a write");
endmodule

// ==== design/cabw_pkg.sv ====
// Constants and types shared by the arithmetic, branch and watchdog-clear decoder
package cabw_pkg;
  localparam int OP_W = 14;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int JUMP_W = 12;
  // Opcode patterns
  localparam logic [13:0] WDT_CLEAR_CODE = 14'h0004;
  localparam logic [5:0] COMPLEMENT_CODE = 6'h09;
  localparam logic [5:0] DECREMENT_CODE = 6'h03;
  localparam logic [5:0] DEC_SKIP_CODE = 6'h0b;
  localparam logic [5:0] INCREMENT_CODE = 6'h0a;
  localparam logic [1:0] JUMP_CODE = 2'h3;
  // Opcode field positions
  localparam int DEST_BIT = 7;
  localparam int GROUP_LSB = 8;
  localparam int JUMP_LSB = 12;
  // APB register byte offsets
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] STAT_OFF = 12'h004;
  localparam logic [11:0] RESULT_OFF = 12'h008;
  localparam int PADDR_W = 12;
  // Control bit positions and reset values
  localparam int CTRL_DECODE_EN = 0;
  localparam int CTRL_WDT_EN = 1;
  localparam logic CTRL_DECODE_EN_RST = 1'b1;
  localparam logic CTRL_WDT_EN_RST = 1'b0;
  localparam logic TIMEOUT_RST = 1'b1;
  localparam logic POWERDOWN_RST = 1'b1;
  localparam logic [7:0] ONE8 = 8'h01;
  localparam logic [7:0] ZERO8 = 8'h00;

  typedef enum logic [0:0] {
    ST_RUN = 1'b0,
    ST_NOP = 1'b1
  } cabw_state_t;

  typedef enum logic [1:0] {
    K_NONE = 2'h0,
    K_COM  = 2'h1,
    K_DEC  = 2'h2,
    K_INC  = 2'h3
  } cabw_kind_t;
endpackage

// ==== tb/cabw_decoder_tb.sv ====
// Self-checking testbench for the arithmetic, branch and watchdog-clear decoder
`timescale 1ns/1ps
module cabw_decoder_tb;
  import cabw_pkg::*;
  // Clock, reset and bus
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        er;
  // Opcode side
  logic        op_valid, wdt_timeout, sleep_entry;
  logic [13:0] opcode;
  logic [7:0]  file_rdata, file_wdata, acc_wdata;
  logic [6:0]  file_addr;
  logic        file_we, acc_we, zero_we, zero_value, pc_load, flush_pulse;
  logic [11:0] pc_target;
  logic        wdt_clear, watchdog_enable_ctl, timeout_status_bit, powerdown_status_bit;
  cabw_state_t st;
  int          error_cnt, comparisons, cycles;

  cabw_decoder dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .op_valid(op_valid), .opcode(opcode), .file_rdata(file_rdata),
    .wdt_timeout(wdt_timeout), .sleep_entry(sleep_entry), .file_addr(file_addr),
    .file_we(file_we), .file_wdata(file_wdata), .acc_we(acc_we), .acc_wdata(acc_wdata),
    .zero_we(zero_we), .zero_value(zero_value), .pc_load(pc_load), .pc_target(pc_target),
    .flush_pulse(flush_pulse), .state(st), .wdt_clear(wdt_clear),
    .watchdog_enable_ctl(watchdog_enable_ctl), .timeout_status_bit(timeout_status_bit),
    .powerdown_status_bit(powerdown_status_bit));

  initial pclk = 1'b0;
  always #50 pclk = ~pclk;

  task automatic end_sim();
    if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", n, e, s);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // Present op, then nxt in the following slot; sample op's results
  task automatic run(input logic [13:0] op, input logic [7:0] r, input logic [13:0] nxt);
    @(posedge pclk);
    op_valid <= 1'b1; opcode <= op; file_rdata <= r;
    @(posedge pclk);
    opcode <= nxt;
    @(negedge pclk);
  endtask

  task automatic quiet();
    chk("file_we", file_we, 0);
    chk("acc_we", acc_we, 0);
    chk("zero_we", zero_we, 0);
    chk("pc_load", pc_load, 0);
    chk("wdt_clear", wdt_clear, 0);
    chk("flush_pulse", flush_pulse, 0);
  endtask

  task automatic fin();
    @(posedge pclk);
    op_valid <= 1'b0;
    @(negedge pclk);
    quiet();
    chk("state", st, ST_RUN);
  endtask

  task automatic t_reset();
    apb(1'b0, CTRL_OFF, 0); chk("ctrl", rd, 32'h1);
    apb(1'b0, STAT_OFF, 0); chk("stat", rd, 32'h3);
    apb(1'b1, STAT_OFF, 32'hf); chk("stat_wr_err", er, 0);
    apb(1'b0, STAT_OFF, 0); chk("stat_ro", rd, 32'h3);
    apb(1'b0, 12'h00c, 0); chk("unmapped_err", er, 1);
    chk("unmapped_data", rd, 0);
  endtask

  task automatic t_alu();
    logic [5:0] c;
    logic [7:0] rv [6] = '{8'h13, 8'h01, 8'hff, 8'hff, 8'h80, 8'h7f};
    logic [7:0] ev [6] = '{8'hec, 8'h00, 8'h00, 8'h00, 8'h7f, 8'h80};
    for (int i = 0; i < 6; i++) begin
      for (int d = 0; d < 2; d++) begin
        c = (i % 3 == 0) ? COMPLEMENT_CODE : (i % 3 == 1) ? DECREMENT_CODE : INCREMENT_CODE;
        run({c, d[0], 7'h7f - 7'(i)}, rv[i], 14'h0000);
        chk("file_we", file_we, d);
        chk("acc_we", acc_we, 1 - d);
        if (d == 1) begin
          chk("file_addr", file_addr, 7'h7f - 7'(i));
          chk("file_wdata", file_wdata, ev[i]);
        end else begin
          chk("acc_wdata", acc_wdata, ev[i]);
        end
        chk("zero_we", zero_we, 1);
        chk("zero_value", zero_value, ev[i] == 8'h00);
        fin();
      end
    end
  endtask

  task automatic t_skip();
    run({DEC_SKIP_CODE, 1'b1, 7'h2a}, 8'h05, 14'h0000);
    chk("file_wdata", file_wdata, 8'h04);
    chk("skip_zero_we", zero_we, 0);
    chk("skip_flush", flush_pulse, 0);
    fin();
    run({DEC_SKIP_CODE, 1'b0, 7'h2a}, 8'h01, {INCREMENT_CODE, 1'b1, 7'h11});
    chk("acc_wdata", acc_wdata, 8'h00);
    chk("skip_zero_we", zero_we, 0);
    chk("flush", flush_pulse, 1);
    chk("nop_state", st, ST_NOP);
    fin();
  endtask

  task automatic t_jump();
    logic [11:0] tg [2] = '{12'hfff, 12'h000};
    for (int i = 0; i < 2; i++) begin
      run({JUMP_CODE, tg[i]}, 8'h00, {INCREMENT_CODE, 1'b0, 7'h01});
      chk("pc_load", pc_load, 1);
      chk("pc_target", pc_target, tg[i]);
      chk("jump_zero_we", zero_we, 0);
      chk("flush", flush_pulse, 1);
      chk("jump_state", st, ST_NOP);
      fin();
    end
  endtask

  task automatic t_wdt();
    @(posedge pclk);
    wdt_timeout <= 1'b1; sleep_entry <= 1'b1;
    @(posedge pclk);
    wdt_timeout <= 1'b0; sleep_entry <= 1'b0;
    @(negedge pclk);
    chk("timeout", timeout_status_bit, 0);
    chk("powerdown", powerdown_status_bit, 0);
    run(WDT_CLEAR_CODE, 8'h00, 14'h0000);
    chk("wdt_clear", wdt_clear, 1);
    chk("wdt_enable", watchdog_enable_ctl, 1);
    chk("timeout", timeout_status_bit, 1);
    chk("powerdown", powerdown_status_bit, 1);
    fin();
    apb(1'b0, STAT_OFF, 0); chk("stat", rd, 32'h7);
  endtask

  task automatic t_other();
    logic [13:0] fo [4] = '{14'h0180, 14'h2123, 14'h0703, 14'h1d45};
    foreach (fo[i]) begin
      run(fo[i], 8'h01, 14'h0000);
      quiet();
      fin();
    end
    run({INCREMENT_CODE, 1'b0, 7'h05}, 8'h41, 14'h0000);
    fin();
    apb(1'b1, CTRL_OFF, 32'h2);
    run({INCREMENT_CODE, 1'b0, 7'h05}, 8'h10, 14'h0000);
    quiet();
    fin();
    apb(1'b0, RESULT_OFF, 0); chk("result", rd, 32'h42);
    apb(1'b1, CTRL_OFF, 32'h3);
    apb(1'b0, CTRL_OFF, 0); chk("ctrl", rd, 32'h3);
    apb(1'b1, CTRL_OFF, 32'h1);
    apb(1'b0, CTRL_OFF, 0); chk("wdt_off", rd, 32'h1);
  endtask

  initial begin
    {presetn, psel, penable, pwrite, op_valid, wdt_timeout, sleep_entry} = '0;
    paddr = '0; pwdata = '0; opcode = '0; file_rdata = '0;
    error_cnt = 0; comparisons = 0; cycles = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_alu();
    t_skip();
    t_jump();
    t_wdt();
    t_other();
    end_sim();
  end
endmodule
